/* File: inc/gtm_consts.svh */
// constants of the guard timer: offsets, field positions, reset values, keys
`ifndef GTM_CONSTS_SVH
`define GTM_CONSTS_SVH
`define GTM_MASTER_ADDR   8'hf0
`define GTM_COMMAND_ADDR  8'hf1
`define GTM_RUN_BIT       7
`define GTM_PER_HI        6
`define GTM_PER_LO        5
`define GTM_EXT_BIT       4
`define GTM_RSVD_VALUE    4'h3
`define GTM_RUN_RESET     1'h1
`define GTM_PER_RESET     2'h3
`define GTM_EXT_RESET     1'h1
`define GTM_KEY_STOP      8'hb1
`define GTM_KEY_RESTART   8'h4e
`define GTM_PULSE_CYCLES  16
`define GTM_SHIFT_BASE    16
`endif

/* File: inc/gtm_pkg.sv */
// types of the guard timer
package gtm_pkg;
  typedef enum logic [1:0] {
    GTM_P16,
    GTM_P18,
    GTM_P20,
    GTM_P22
  } gtm_period_t;
  typedef enum logic [1:0] {
    GTM_RUNNING,
    GTM_STOPPED,
    GTM_FIRING
  } gtm_state_t;
endpackage : gtm_pkg

/* File: logic/gtm_guard_timer.sv */
// guard timer: master and command registers, counter, timeout reset
//
// Summary of operation
// - timeout acts as active-low reset merged with synchronised reset pin level to reset the core.
// - run enable at master bit 7, set by reset, software may set it.
// - stop only by clearing run enable and then writing stop key.
// - restart key written to command register clears the count.
// - period field bits 6-5 selects 2^16..2^22 cycles; reset value 11.
// - master bit 4 set: timeout drives reset pin low; else internal only.
// - reset pin driven open-drain; external mode is the default.
// - master bits 3-0 reserved, read back fixed pattern 0011.
// - master register at io F0, command register at F1.
// - command register write-only, reads return no stored value.
// - no halt-mode field in the master register.
`timescale 1ns/1ps
`default_nettype none
`include "gtm_consts.svh"
module gtm_guard_timer #(
  parameter int PULSE_CYCLES = `GTM_PULSE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic [7:0] ioAddr,
  input  wire logic [7:0] ioWrData,
  input  wire logic ioWr,
  input  wire logic ioRd,
  output logic      [7:0] ioRdData,
  output logic      ioRdHit,
  input  wire logic resetPinIn,
  output logic      resetPinOut,
  output logic      resetPinOe,
  output logic      coreReset_n,
  output gtm_pkg::gtm_state_t guardState,
  output logic      timeoutPulse
);
  import gtm_pkg::*;

  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) $error("PULSE_CYCLES out of range");
  end

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  logic masterWr;
  logic commandWr;
  logic keyStop;
  logic keyRestart;
  assign masterWr   = ioWr && (ioAddr == `GTM_MASTER_ADDR);
  assign commandWr  = ioWr && (ioAddr == `GTM_COMMAND_ADDR);
  assign keyStop    = commandWr && (ioWrData == `GTM_KEY_STOP);
  assign keyRestart = commandWr && (ioWrData == `GTM_KEY_RESTART);

  // ------------------------------------------------------------
  // master register fields
  // ------------------------------------------------------------
  logic        runEnable;
  gtm_period_t periodSel;
  logic        extReset;
  logic        pinSync;
  logic        firing;
  logic [7:0]  pulseCnt;

  // the enable bit only records intent; stopping needs the key as well
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      runEnable <= `GTM_RUN_RESET;
      periodSel <= gtm_period_t'(`GTM_PER_RESET);
      extReset  <= `GTM_EXT_RESET;
    end else if (masterWr) begin
      runEnable <= ioWrData[`GTM_RUN_BIT];
      periodSel <= gtm_period_t'(ioWrData[`GTM_PER_HI:`GTM_PER_LO]);
      extReset  <= ioWrData[`GTM_EXT_BIT];
    end
  end

  // ------------------------------------------------------------
  // state and counter
  // ------------------------------------------------------------
  gtm_state_t state;
  logic [21:0] count;
  logic [21:0] limit;
  logic        periodChange;
  logic        expired;

  always_comb begin
    unique case (periodSel)
      GTM_P16: limit = 22'h00ffff;
      GTM_P18: limit = 22'h03ffff;
      GTM_P20: limit = 22'h0fffff;
      GTM_P22: limit = 22'h3fffff;
    endcase
  end

  assign periodChange = masterWr &&
                        (ioWrData[`GTM_PER_HI:`GTM_PER_LO] != periodSel);
  assign expired      = (state == GTM_RUNNING) && (count == limit);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= GTM_RUNNING;
    end else begin
      unique case (state)
        GTM_RUNNING: begin
          if (expired) begin
            state <= GTM_FIRING;
          end else if (keyStop && !runEnable) begin
            state <= GTM_STOPPED;
          end
        end
        GTM_STOPPED: begin
          if (masterWr && ioWrData[`GTM_RUN_BIT]) begin
            state <= GTM_RUNNING;
          end
        end
        GTM_FIRING: begin
          if (pulseCnt == 8'(PULSE_CYCLES - 1)) begin
            state <= GTM_RUNNING;
          end
        end
        default: state <= GTM_RUNNING;
      endcase
    end
  end

  // among command bytes only the two keys touch the count; any other command byte is ignored
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= 22'h000000;
    end else if (state != GTM_RUNNING) begin
      count <= 22'h000000;
    end else if (keyRestart || periodChange || expired) begin
      count <= 22'h000000;
    end else begin
      count <= count + 22'h000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pulseCnt <= 8'h00;
    end else if (state == GTM_FIRING) begin
      pulseCnt <= pulseCnt + 8'h01;
    end else begin
      pulseCnt <= 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      firing       <= 1'b0;
      timeoutPulse <= 1'b0;
    end else begin
      firing       <= expired || (state == GTM_FIRING &&
                      pulseCnt != 8'(PULSE_CYCLES - 1));
      timeoutPulse <= expired;
    end
  end

  // ------------------------------------------------------------
  // reset outputs
  // ------------------------------------------------------------
  gtm_sync u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (resetPinIn),
    .dout     (pinSync)
  );

  // open drain: only ever pulls low, never drives high
  assign resetPinOut = 1'b0;
  assign resetPinOe  = firing && extReset;
  // timeout is ORed low-active into the core reset; the pin level is seen too
  assign coreReset_n = !firing && pinSync;
  assign guardState  = state;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // command register has no read path; the halt field does not exist
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ioRdData <= 8'h00;
      ioRdHit  <= 1'b0;
    end else begin
      ioRdHit  <= ioRd && (ioAddr == `GTM_MASTER_ADDR);
      if (ioRd && ioAddr == `GTM_MASTER_ADDR) begin
        ioRdData <= {runEnable, periodSel, extReset, `GTM_RSVD_VALUE};
      end else begin
        ioRdData <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_stop_needs_key: assert property (
    $rose(state == GTM_STOPPED) |-> $past(keyStop) && !$past(runEnable))
    else $error("stopped without key sequence");
  chk_restart_clears: assert property (
    keyRestart && state == GTM_RUNNING |=> count == 22'h000000)
    else $error("restart key did not clear count");
  chk_other_cmd_keeps: assert property (
    commandWr && !keyStop && !keyRestart && !masterWr && state == GTM_RUNNING && !expired
      |=> count == $past(count) + 22'h000001)
    else $error("stray command changed count");
  chk_timeout_limit: assert property (
    expired |-> count == limit ##1 state == GTM_FIRING)
    else $error("timeout at wrong count");
  chk_pin_ext_mode: assert property (
    resetPinOe |-> extReset && !coreReset_n && !resetPinOut)
    else $error("pin pulled without external mode");
  chk_core_reset: assert property (
    expired |=> !coreReset_n)
    else $error("timeout did not reset core");
  chk_master_read: assert property (
    ioRd && ioAddr == `GTM_MASTER_ADDR |=> ioRdData[3:0] == 4'h3 && ioRdHit)
    else $error("reserved bits misread");
  chk_cmd_read_zero: assert property (
    ioRd && ioAddr == `GTM_COMMAND_ADDR |=> ioRdData == 8'h00 && !ioRdHit)
    else $error("command register readable");
  chk_period_restart: assert property (
    periodChange && state == GTM_RUNNING |=> count == 22'h000000)
    else $error("period change did not restart count");
  chk_fire_ends: assert property (
    $fell(state == GTM_FIRING) |-> count == 22'h000000)
    else $error("count not zero after timeout");
  chk_run_reset: assert property (
    $rose(rst_n) |-> runEnable && state == GTM_RUNNING)
    else $error("enable not set after reset");


  // ------------------------------------------------------------
  // further checks on keys, pin and firing
  // ------------------------------------------------------------
  // the key alone must not stop a timer whose enable bit is still set
  chk_stop_key_alone: assert property (
    keyStop && runEnable && state == GTM_RUNNING && !expired |=> state == GTM_RUNNING)
    else $error("stop key alone stopped the timer");
  chk_stray_no_stop: assert property (
    commandWr && !keyStop && !keyRestart && state == GTM_RUNNING && !expired
      |=> state == GTM_RUNNING)
    else $error("stray command changed state");
  chk_internal_only: assert property (
    !extReset |-> !resetPinOe)
    else $error("pin pulled in internal mode");
  chk_open_drain: assert property (
    resetPinOut == 1'b0)
    else $error("reset pin driven high");
  chk_fire_holds: assert property (
    state == GTM_FIRING |-> count == 22'h000000)
    else $error("count moved while firing");
  chk_pulse_single: assert property (
    timeoutPulse |=> !timeoutPulse)
    else $error("timeout pulse longer than one cycle");
  // a stopped timer stays stopped until the enable bit is written as one
  chk_stopped_holds: assert property (
    state == GTM_STOPPED && !(masterWr && ioWrData[`GTM_RUN_BIT]) |=> state == GTM_STOPPED)
    else $error("stopped timer restarted without enable");
  chk_restart_runs: assert property (
    state == GTM_STOPPED && masterWr && ioWrData[`GTM_RUN_BIT] |=> state == GTM_RUNNING)
    else $error("enable write did not restart timer");

  cov_internal: cover property (expired && !extReset);
  cov_stop: cover property (keyStop && !runEnable && state == GTM_RUNNING);
  cov_timeout: cover property (expired);
  cov_ext_pull: cover property (resetPinOe);
  cov_restart: cover property (keyRestart && state == GTM_RUNNING);
endmodule : gtm_guard_timer
`default_nettype wire

/* File: logic/gtm_sync.sv */
// two-flop synchroniser for the reset pin level
`timescale 1ns/1ps
`default_nettype none
module gtm_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic stage1;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : gtm_sync
`default_nettype wire

/* File: sim/gtm_testbench.sv */
// self-checking bench for the guard timer
`timescale 1ns/1ps
`default_nettype none
`include "gtm_consts.svh"
module testbench;
  import gtm_pkg::*;
  localparam int PULSE = 4;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  ioAddr   = 8'h00;
  logic [7:0]  ioWrData = 8'h00;
  logic        ioWr     = 1'b0;
  logic        ioRd     = 1'b0;
  logic        extPull_n = 1'b1;
  logic [7:0]  ioRdData;
  logic        ioRdHit;
  logic        resetPinOut;
  logic        resetPinOe;
  logic        coreReset_n;
  gtm_state_t  guardState;
  logic        timeoutPulse;
  wire         resetPinIn = (resetPinOe ? resetPinOut : 1'b1) & extPull_n;
  logic        rdPend = 1'b0;
  logic [8:0]  expQ[$];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          seed = 8977;
  int          cnt;
  logic [7:0]  rv;

  gtm_guard_timer #(.PULSE_CYCLES(PULSE)) u_gtm_guard_timer (
    .core_clk(core_clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData), .ioRdHit(ioRdHit),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .coreReset_n(coreReset_n), .guardState(guardState), .timeoutPulse(timeoutPulse)
  );

  always #50 core_clk = ~core_clk;

  task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    ioWr <= 1'b1;
    ioAddr <= a;
    ioWrData <= d;
    @(posedge core_clk);
    ioWr <= 1'b0;
  endtask : wr

  // the expected answer is queued when the read is issued
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    @(posedge core_clk);
    ioRd <= 1'b1;
    ioAddr <= a;
    expQ.push_back(e);
    @(posedge core_clk);
    ioRd <= 1'b0;
  endtask : rd

  task automatic chkState(input gtm_state_t e);
    @(posedge core_clk);
    @(negedge core_clk);
    cmp("guardState", {7'h00, e}, {7'h00, guardState});
  endtask : chkState

  // -----------------------------------------------------------------
  // read monitor
  // -----------------------------------------------------------------
  always @(posedge core_clk) rdPend <= ioRd;
  always @(negedge core_clk) begin
    if (rdPend) begin
      if (expQ.size() == 0) cmp("read queue", 9'h000, 9'h1ff);
      else cmp("read", expQ.pop_front(), {ioRdHit, ioRdData});
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // -----------------------------------------------------------------
  // watchdog: the sequence needs about 90k cycles
  // -----------------------------------------------------------------
  initial begin
    repeat (120000) @(posedge core_clk);
    n_errors++;
    $display("unexpected timeout: expected done seen hang");
    test_done();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`GTM_MASTER_ADDR, 9'h1f3);
    rd(`GTM_COMMAND_ADDR, 9'h000);
    repeat (3) begin
      rv = 8'($random(seed));
      if (rv == `GTM_MASTER_ADDR) rv = 8'h10;
      if (rv == `GTM_COMMAND_ADDR) rv = 8'h11;
      rd(rv, 9'h000);
    end
    wr(`GTM_COMMAND_ADDR, `GTM_KEY_STOP);
    chkState(GTM_RUNNING);
    wr(`GTM_MASTER_ADDR, 8'h33);
    rd(`GTM_MASTER_ADDR, 9'h133);
    chkState(GTM_RUNNING);
    repeat (4) begin
      rv = 8'($random(seed));
      if (rv == `GTM_KEY_STOP || rv == `GTM_KEY_RESTART) rv = 8'h00;
      wr(`GTM_COMMAND_ADDR, rv);
      chkState(GTM_RUNNING);
    end
    wr(`GTM_COMMAND_ADDR, `GTM_KEY_STOP);
    chkState(GTM_STOPPED);
    wr(`GTM_MASTER_ADDR, 8'h93);
    chkState(GTM_RUNNING);
    // pulling the shared pin from outside must reset the core
    @(posedge core_clk);
    extPull_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    cmp("coreReset_n", 9'h000, {8'h00, coreReset_n});
    @(posedge core_clk);
    extPull_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // shortest period, late restart key, then let it expire
    repeat (20000) @(posedge core_clk);
    wr(`GTM_COMMAND_ADDR, `GTM_KEY_RESTART);
    cnt = 0;
    while (timeoutPulse !== 1'b1 && cnt < 70000) begin
      @(negedge core_clk);
      cnt++;
    end
    cmp("period", 9'h001, {8'h00, cnt >= 65535 && cnt <= 65538});
    @(negedge core_clk);
    cmp("oe", 9'h001, {8'h00, resetPinOe});
    cmp("pinOut", 9'h000, {8'h00, resetPinOut});
    cmp("coreReset_n", 9'h000, {8'h00, coreReset_n});
    cmp("guardState", {7'h00, GTM_FIRING}, {7'h00, guardState});
    cnt = 1;
    while (coreReset_n !== 1'b1 && cnt < 50) begin
      @(negedge core_clk);
      cnt++;
    end
    cmp("pulse", 9'h001, {8'h00, cnt >= PULSE - 1 && cnt <= PULSE + 3});
    cmp("oe off", 9'h000, {8'h00, resetPinOe});
    chkState(GTM_RUNNING);
    rd(`GTM_MASTER_ADDR, 9'h193);
    repeat (3) @(posedge core_clk);
    test_done();
  end
endmodule : testbench
`default_nettype wire
